// ---- rtl/acs_map.svh ----
// register offsets, field positions and reset values of the converter status block
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// byte offsets on the register port
`define ACS_OFF_CHAN_ENABLE 8'h10
`define ACS_OFF_CHAN_DISABLE 8'h14
`define ACS_OFF_CHAN_VIEW 8'h18
`define ACS_OFF_FLAGS 8'h1c
`define ACS_OFF_LAST_RESULT 8'h20
`define ACS_OFF_IRQ_SET 8'h24
`define ACS_OFF_IRQ_CLEAR 8'h28
`define ACS_OFF_IRQ_VIEW 8'h2c
`define ACS_OFF_RESULT_BASE 8'h30
`define ACS_OFF_EVT_STATUS 8'h40
`define ACS_OFF_EVT_CLEAR 8'h44
`define ACS_OFF_EVT_ENABLE 8'h48

// layout of the flags register
`define ACS_NUM_CH 4
`define ACS_POS_DONE 0
`define ACS_POS_OVR 8
`define ACS_POS_READY 16
`define ACS_POS_GOVR 17
`define ACS_POS_RXDONE 18
`define ACS_POS_RXEMPTY 19
`define ACS_FLAG_W 20

// event status layout
`define ACS_EVT_CONV 0
`define ACS_EVT_CHOVR 1
`define ACS_EVT_GOVR 2
`define ACS_EVT_RXDONE 3
`define ACS_EVT_W 4

// reset values
`define ACS_RST_CHAN_EN 4'h0
`define ACS_RST_IRQ_MASK 20'h00000
`define ACS_RST_EVT_EN 4'h0

`endif

// ---- rtl/acs_pkg.sv ----
// types shared by the converter status block and its surroundings
package acs_pkg;

   // one finished conversion from the sequencer
   typedef struct packed {
      logic valid;
      logic [1:0] chan;
      logic [15:0] data;
   } acs_conv_t;

   // overrun events from the sequencer
   typedef struct packed {
      logic [3:0] chanOvr;
      logic genOvr;
   } acs_ovr_t;

   // receive counters of the transfer engine
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] nextCount;
      logic written;
   } acs_rx_t;

   // register port request
   typedef struct packed {
      logic wrStrobe;
      logic rdStrobe;
      logic [7:0] addr;
      logic [31:0] wrData;
   } acs_bus_t;

endpackage

// ---- rtl/acs_status_regs.sv ----
// register side of a four-channel converter: channel enables, flags, results, interrupt
`timescale 1ns/1ps

`include "acs_map.svh"

module acs_status_regs
   import acs_pkg::*;
#(
   parameter int DATA_W = 10
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // register port
   input wire acs_bus_t bus,
   output logic [31:0] rdData_r,
   // converter sequencer
   input wire acs_conv_t conv,
   input wire acs_ovr_t ovr,
   output logic [3:0] chanEnable_r,
   // receive transfer engine
   input wire acs_rx_t rx,
   // interrupt request
   output logic irq_r
);

   // refuse widths the result fields cannot carry
   // the converter hands over sixteen bits, so a wider result has no source,
   // and a zero-width result register cannot be built at all
   initial begin
      if (DATA_W < 1 || DATA_W > 16) begin
         $error("DATA_W must lie between 1 and 16");
      end
   end

   // address match helper, used for every strobe decode below
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // write decodes
   // each strobe is one cycle long, so every decode below is a one-cycle pulse;
   // the master never raises both strobes, so a write decode and a read decode
   // never fall in the same cycle
   // writes to read-only offsets match none of these and are dropped
   wire wrChEn = bus.wrStrobe && hit(bus.addr, `ACS_OFF_CHAN_ENABLE);
   wire wrChDis = bus.wrStrobe && hit(bus.addr, `ACS_OFF_CHAN_DISABLE);
   wire wrIrqSet = bus.wrStrobe && hit(bus.addr, `ACS_OFF_IRQ_SET);
   wire wrIrqClr = bus.wrStrobe && hit(bus.addr, `ACS_OFF_IRQ_CLEAR);
   wire wrEvtClr = bus.wrStrobe && hit(bus.addr, `ACS_OFF_EVT_CLEAR);
   wire wrEvtEn = bus.wrStrobe && hit(bus.addr, `ACS_OFF_EVT_ENABLE);

   // read decodes that carry a side effect
   // these clear flags at the same edge that captures the read data, so the
   // word handed back still shows the flags as they stood before the read
   wire rdFlags = bus.rdStrobe && hit(bus.addr, `ACS_OFF_FLAGS);
   wire rdLast = bus.rdStrobe && hit(bus.addr, `ACS_OFF_LAST_RESULT);

   // state
   // every flag except the receive empty bit lives in its own flop so set and clear priority can be
   // decided per flag; the result array is small enough for flops as well
   logic [3:0] chanEnable_nxt; // next value of the channel enables
   logic [3:0] done_r; // per-channel done flags
   logic [3:0] chanOvr_r; // per-channel overrun flags
   logic ready_r; // result ready flag
   logic govr_r; // general overrun flag
   logic rxDone_r; // receive count done flag
   logic rxZeroPrev_r; // receive counter was zero last cycle
   logic [DATA_W-1:0] last_r; // last converted value
   logic [DATA_W-1:0] chanRes_r [`ACS_NUM_CH]; // per-channel results
   logic [`ACS_FLAG_W-1:0] irqMask_r; // interrupt source enables
   logic [`ACS_EVT_W-1:0] evtStat_r; // sticky event bits
   logic [`ACS_EVT_W-1:0] evtEn_r; // event interrupt enables

   // conversion and counter conditions
   // the receive counters come from the transfer engine on this same clock,
   // so they are used without synchronisers
   // rxReach fires once, on the cycle the counter first reads zero, so a
   // counter that rests at zero does not set the done flag again after a write
   wire [DATA_W-1:0] convVal = conv.data[DATA_W-1:0];
   wire [3:0] convOneHot = 4'h1 << conv.chan;
   wire convEnabled = conv.valid && chanEnable_r[conv.chan];
   wire rxZero = (rx.count == 16'h0000);
   wire rxReach = rxZero && !rxZeroPrev_r;
   wire rxEmpty = rxZero && (rx.nextCount == 16'h0000);

   // channel enable next value
   // set bits enable, disable bits win when both arrive together
   assign chanEnable_nxt = (chanEnable_r | (wrChEn ? bus.wrData[3:0] : 4'h0))
      & ~(wrChDis ? bus.wrData[3:0] : 4'h0);

   // channel enable register
   // software must not disable a channel while it converts; if it does, the
   // done flag of that channel is cleared by the disable, but its result word carries no
   // meaning until the next conversion, and nothing here tries to repair the result
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         chanEnable_r <= `ACS_RST_CHAN_EN;
      end else begin
         chanEnable_r <= chanEnable_nxt;
      end
   end

   // per-channel flags and results
   // one copy per channel: a done flag, an overrun flag and a result word
   // a conversion for a disabled channel touches none of these, only the
   // last result register, the ready flag and the conversion event bit further down
   genvar g;
   generate
      for (g = 0; g < `ACS_NUM_CH; g++) begin : gCh
         // this channel finished a conversion while enabled
         wire chDone = convEnabled && convOneHot[g];
         // reading this channel's result register
         wire rdRes = bus.rdStrobe
            && hit(bus.addr, 8'(`ACS_OFF_RESULT_BASE + 4 * g));

         // done flag: set by conversion, cleared by result read
         // or by disabling the channel; a new result wins over the read
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               done_r[g] <= 1'b0;
            end else if (chDone) begin
               done_r[g] <= 1'b1;
            end else if (rdRes || !chanEnable_nxt[g]) begin
               done_r[g] <= 1'b0;
            end
         end

         // overrun flag: set wins over the flags read
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               chanOvr_r[g] <= 1'b0;
            end else if (ovr.chanOvr[g]) begin
               chanOvr_r[g] <= 1'b1;
            end else if (rdFlags) begin
               chanOvr_r[g] <= 1'b0;
            end
         end

         // result register: loaded only for an enabled channel
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               chanRes_r[g] <= '0;
            end else if (chDone) begin
               chanRes_r[g] <= convVal;
            end
         end
      end
   endgenerate

   // last result: every completed conversion, enabled channel or not
   // the value holds until the next conversion ends; a read does not touch it
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         last_r <= '0;
      end else if (conv.valid) begin
         last_r <= convVal;
      end
   end

   // ready flag: new result wins over the read that would clear it
   // losing the set would hide a fresh result from software, while losing
   // the clear only costs one extra read of the last result
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ready_r <= 1'b0;
      end else if (conv.valid) begin
         ready_r <= 1'b1;
      end else if (rdLast) begin
         ready_r <= 1'b0;
      end
   end

   // general overrun flag
   // cleared by any read of the flags word, like the per-channel overruns;
   // an overrun in the read cycle itself survives the read
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         govr_r <= 1'b0;
      end else if (ovr.genOvr) begin
         govr_r <= 1'b1;
      end else if (rdFlags) begin
         govr_r <= 1'b0;
      end
   end

   // receive counter zero history, for the reach edge
   // reset leaves it low, so a counter already at zero after reset is seen
   // as having just reached zero
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rxZeroPrev_r <= 1'b0;
      end else begin
         rxZeroPrev_r <= rxZero;
      end
   end

   // receive done flag: reaching zero wins over a counter write
   // a write to either counter clears it; the transfer engine reports such
   // a write as a one-cycle pulse on rx.written
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rxDone_r <= 1'b0;
      end else if (rxReach) begin
         rxDone_r <= 1'b1;
      end else if (rx.written) begin
         rxDone_r <= 1'b0;
      end
   end

   // assembled flags word
   // done bits are gated by the live enables so a disabled channel reads
   // zero at once; the empty bit is a pure level of both counters and has
   // no flop of its own
   logic [`ACS_FLAG_W-1:0] flags;
   always_comb begin
      flags = '0;
      flags[`ACS_POS_DONE +: 4] = done_r & chanEnable_r;
      flags[`ACS_POS_OVR +: 4] = chanOvr_r;
      flags[`ACS_POS_READY] = ready_r;
      flags[`ACS_POS_GOVR] = govr_r;
      flags[`ACS_POS_RXDONE] = rxDone_r;
      flags[`ACS_POS_RXEMPTY] = rxEmpty;
   end

   // interrupt source enables: set bits first, clear bits win
   // the set and clear registers are write-only views of this one mask;
   // zero bits in either write leave the mask alone
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irqMask_r <= `ACS_RST_IRQ_MASK;
      end else begin
         irqMask_r <= (irqMask_r
            | (wrIrqSet ? bus.wrData[`ACS_FLAG_W-1:0] : '0))
            & ~(wrIrqClr ? bus.wrData[`ACS_FLAG_W-1:0] : '0);
      end
   end

   // event sources for the sticky event register
   // these catch events that the clear-on-read flags could lose between two
   // reads; software clears them by writing ones to the clear offset
   wire [`ACS_EVT_W-1:0] evtIn = {rxReach, ovr.genOvr, |ovr.chanOvr, conv.valid};

   // sticky events: a new event wins over the write-one clear
   // an event in the clear cycle stays set, so it is never lost
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         evtStat_r <= '0;
      end else begin
         evtStat_r <= (evtStat_r
            & ~(wrEvtClr ? bus.wrData[`ACS_EVT_W-1:0] : '0)) | evtIn;
      end
   end

   // event interrupt enables
   // a plain read-write register, written as a whole word
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         evtEn_r <= `ACS_RST_EVT_EN;
      end else if (wrEvtEn) begin
         evtEn_r <= bus.wrData[`ACS_EVT_W-1:0];
      end
   end

   // interrupt request, registered so the output comes from a flop
   // the request follows flags and masks one cycle late; software that
   // clears a source sees the line drop one cycle after its write lands
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= (|(flags & irqMask_r)) || (|(evtStat_r & evtEn_r));
      end
   end

   // read selection; write-only and unmapped offsets read as zero
   // unused upper bits of every word read as zero
   // the selection is decoded from the address alone; the strobe only
   // decides below whether the selected word is captured
   logic [31:0] rdSel;
   always_comb begin
      rdSel = 32'h0000_0000;
      case (bus.addr)
         `ACS_OFF_CHAN_VIEW: rdSel[3:0] = chanEnable_r;
         `ACS_OFF_FLAGS: rdSel[`ACS_FLAG_W-1:0] = flags;
         `ACS_OFF_LAST_RESULT: rdSel[DATA_W-1:0] = last_r;
         `ACS_OFF_IRQ_VIEW: rdSel[`ACS_FLAG_W-1:0] = irqMask_r;
         `ACS_OFF_EVT_STATUS: rdSel[`ACS_EVT_W-1:0] = evtStat_r;
         `ACS_OFF_EVT_ENABLE: rdSel[`ACS_EVT_W-1:0] = evtEn_r;
         8'h30: rdSel[DATA_W-1:0] = chanRes_r[0];
         8'h34: rdSel[DATA_W-1:0] = chanRes_r[1];
         8'h38: rdSel[DATA_W-1:0] = chanRes_r[2];
         8'h3c: rdSel[DATA_W-1:0] = chanRes_r[3];
         default: rdSel = 32'h0000_0000;
      endcase
   end

   // read data stands only in the cycle after the read strobe
   // returning zero in every other cycle keeps stale words off the bus,
   // so the master can only take data in the cycle that carries it
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdData_r <= 32'h0000_0000;
      end else if (bus.rdStrobe) begin
         rdData_r <= rdSel;
      end else begin
         rdData_r <= 32'h0000_0000;
      end
   end

endmodule

// ---- verification/acs_status_regs_monitor.sv ----
// checker of the converter status block as seen at its ports
`timescale 1ns/1ps
module acs_status_regs_monitor
   import acs_pkg::*;
#(
   parameter int DATA_W = 10
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // watched ports
   input wire acs_bus_t bus,
   input wire logic [31:0] rdData_r,
   input wire acs_conv_t conv,
   input wire acs_ovr_t ovr,
   input wire logic [3:0] chanEnable_r,
   input wire acs_rx_t rx,
   input wire logic irq_r
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // decodes of the reads and the mask set write that matter
   wire logic rdF = bus.rdStrobe && bus.addr == 8'h1c;
   wire logic rdL = bus.rdStrobe && bus.addr == 8'h20;
   wire logic setM = bus.wrStrobe && bus.addr == 8'h24;
   // result bits kept by the converter width
   wire logic [15:0] dMask = 16'((32'h1 << DATA_W) - 32'h1);

   a_disable_clears_chan: assert property (bus.wrStrobe && bus.addr == 8'h14
      |=> (chanEnable_r & $past(bus.wrData[3:0])) == 4'h0) else $error("channel not disabled");
   a_view_shows_enable: assert property (bus.rdStrobe && bus.addr == 8'h18
      |=> rdData_r == {28'h0, $past(chanEnable_r)}) else $error("channel view wrong");
   a_done_needs_enable: assert property (rdF
      |=> (rdData_r[3:0] & ~$past(chanEnable_r)) == 4'h0) else $error("done on idle channel");
   a_ovr_clear_read: assert property ((rdF && ovr == '0) ##1 ovr == '0 ##1 rdF
      |=> rdData_r[11:8] == 4'h0 && !rdData_r[17]) else $error("overrun not cleared");
   a_ready_on_conv: assert property (conv.valid ##1 !bus.rdStrobe ##1 rdF
      |=> rdData_r[16]) else $error("ready flag not set");
   a_ready_clear_read: assert property ((rdL && !conv.valid) ##1 !conv.valid ##1 rdF
      |=> !rdData_r[16]) else $error("ready flag not cleared");
   a_rx_empty_level: assert property (rdF && $stable(rx.count) && $stable(rx.nextCount)
      |=> rdData_r[19] == ($past(rx.count) == 16'h0 && $past(rx.nextCount) == 16'h0))
      else $error("receive empty flag wrong");
   a_last_result_hold: assert property (conv.valid ##1 !conv.valid
      ##1 (rdL && !conv.valid)
      |=> rdData_r == {16'h0, $past(conv.data, 3) & dMask}) else $error("last result wrong");
   a_mask_set_view: assert property (setM ##1 !bus.wrStrobe
      ##1 (bus.rdStrobe && bus.addr == 8'h2c)
      |=> (rdData_r[19:0] & $past(bus.wrData[19:0], 3)) == $past(bus.wrData[19:0], 3))
      else $error("mask bit not set");
   a_mask_clear_view: assert property (bus.wrStrobe && bus.addr == 8'h28
      ##1 !bus.wrStrobe ##1 (bus.rdStrobe && bus.addr == 8'h2c)
      |=> (rdData_r[19:0] & $past(bus.wrData[19:0], 3)) == 20'h0)
      else $error("mask bit not cleared");

   // main scenarios reached
   c_conv: cover property (conv.valid && chanEnable_r[conv.chan]);
   c_irq: cover property ($rose(irq_r));
   c_ovr: cover property (ovr.genOvr ##2 rdF);
endmodule

// ---- verification/testbench.sv ----
// self-checking bench of the converter status block
`timescale 1ns/1ps
module testbench;
   import acs_pkg::*;
   logic clock, nrst, irq_r;
   acs_bus_t bus;
   acs_conv_t conv;
   acs_ovr_t ovr;
   acs_rx_t rx;
   logic [31:0] rdData_r;
   logic [3:0] chanEnable_r;
   int n_fail = 0;
   int checked = 0;
   int cycles = 0;

   acs_status_regs #(.DATA_W(10)) dut (.clock(clock), .nrst(nrst), .bus(bus),
      .rdData_r(rdData_r), .conv(conv), .ovr(ovr), .chanEnable_r(chanEnable_r),
      .rx(rx), .irq_r(irq_r));

   // 125 MHz clock
   always #4 clock = ~clock;

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task report_and_stop;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // guard against a hang
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         report_and_stop;
      end
   end

   // one-cycle register write
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      bus.wrStrobe <= 1'h1;
      bus.addr <= a;
      bus.wrData <= d;
      @(posedge clock);
      bus.wrStrobe <= 1'h0;
   endtask

   // one-cycle read, data judged in the following cycle
   task rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      bus.rdStrobe <= 1'h1;
      bus.addr <= a;
      @(posedge clock);
      bus.rdStrobe <= 1'h0;
      #1 chk(rdData_r, exp);
   endtask

   // one finished conversion
   task cnv(input logic [1:0] ch, input logic [15:0] d);
      @(posedge clock);
      conv <= '{1'h1, ch, d};
      @(posedge clock);
      conv.valid <= 1'h0;
   endtask

   task t_chan;
      wr(8'h10, 32'hf);
      wr(8'h14, 32'h5); // no conversion in flight while disabling
      wr(8'h18, 32'hf);
      rd(8'h18, 32'ha);
      rd(8'hfc, 32'h0);
   endtask

   task t_conv;
      cnv(2'h1, 16'h2a5);
      rd(8'h1c, 32'h10002);
      rd(8'h20, 32'h2a5);
      rd(8'h34, 32'h2a5);
      rd(8'h1c, 32'h0);
      cnv(2'h0, 16'h111);
      rd(8'h20, 32'h111);
      rd(8'h1c, 32'h0);
      rd(8'h30, 32'h0);
   endtask

   task t_ovr;
      @(posedge clock);
      ovr <= '{4'h9, 1'h1};
      @(posedge clock);
      ovr <= '0;
      rd(8'h1c, 32'h20900);
      rd(8'h1c, 32'h0);
   endtask

   task t_rx;
      @(posedge clock);
      rx.count <= 16'h0;
      rd(8'h1c, 32'h40000);
      @(posedge clock);
      rx.nextCount <= 16'h0;
      rd(8'h1c, 32'hc0000);
      @(posedge clock);
      rx.written <= 1'h1;
      @(posedge clock);
      rx.written <= 1'h0;
      rd(8'h1c, 32'h80000);
      @(posedge clock);
      rx.count <= 16'h3;
      rx.nextCount <= 16'h3;
      rd(8'h1c, 32'h0);
   endtask

   task t_irq;
      wr(8'h24, 32'h10000);
      rd(8'h2c, 32'h10000);
      chk({31'h0, irq_r}, 32'h0);
      cnv(2'h3, 16'h3ff);
      repeat (2) @(posedge clock);
      #1 chk({31'h0, irq_r}, 32'h1);
      wr(8'h28, 32'h10000);
      rd(8'h2c, 32'h0);
      #1 chk({31'h0, irq_r}, 32'h0);
      rd(8'h3c, 32'h3ff);
   endtask

   // sticky events, their enable and their share of the interrupt
   task t_evt;
      rd(8'h40, 32'hf);
      wr(8'h44, 32'hf);
      rd(8'h40, 32'h0);
      wr(8'h48, 32'h1);
      rd(8'h48, 32'h1);
      #1 chk({31'h0, irq_r}, 32'h0);
      cnv(2'h1, 16'h05a);
      repeat (2) @(posedge clock);
      #1 chk({31'h0, irq_r}, 32'h1);
      wr(8'h14, 32'h2);
      rd(8'h1c, 32'h10000);
      rd(8'h18, 32'h8);
      rd(8'h40, 32'h1);
      wr(8'h44, 32'h1);
      rd(8'h40, 32'h0);
      #1 chk({31'h0, irq_r}, 32'h0);
   endtask

   initial begin
      clock = 1'h0;
      nrst = 1'h0;
      bus = '0;
      conv = '0;
      ovr = '0;
      rx = '{16'h3, 16'h3, 1'h0};
      repeat (4) @(posedge clock);
      nrst <= 1'h1;
      t_chan;
      t_conv;
      t_ovr;
      t_rx;
      t_irq;
      t_evt;
      report_and_stop;
   end
endmodule

bind acs_status_regs acs_status_regs_monitor #(.DATA_W(DATA_W)) mon (.clock, .nrst, .bus,
   .rdData_r, .conv, .ovr, .chanEnable_r, .rx, .irq_r);
